/* File: dtr_regs.sv */
// Serial word capture, decode and per-channel trim, clear and output code registers.
// Assumes sclk, frame_sel_n, sdin, clear_n and straps are asynchronous pins; check_enable is core logic.
`timescale 1ns/1ps
`default_nettype none
module dtr_regs (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic frame_sel_n,
  input wire logic sdin,
  input wire logic clear_n,
  input wire logic addr_strap_high,
  input wire logic addr_strap_low,
  input wire logic check_enable,
  output logic [3:0][15:0] channel_output_code,
  output logic [3:0][15:0] channel_gain_trim,
  output logic [3:0][15:0] channel_offset_trim,
  output logic [3:0][15:0] channel_clear_value,
  output logic [3:0] clear_enable,
  output var dtr_pkg::dtr_ctrl_wr_t ctrl_write
);
  dtr_pkg::dtr_state_t s_reg;
  dtr_pkg::dtr_state_t s_next;

  // A change is accepted only once the second and third stages agree.
  function automatic logic filt(input logic [2:0] st, input logic cur);
    filt = (st[1] == st[2]) ? st[2] : cur;
  endfunction : filt

  function automatic logic [3:0] chan_mask(input logic all, input logic [1:0] ch);
    chan_mask = all ? 4'hf : (4'h1 << ch);
  endfunction : chan_mask

  logic sclk_fall;
  logic frame_end;
  logic [23:0] word;
  logic [5:0] need;
  logic frame_ok;
  logic [2:0] sel;
  logic [1:0] ch;
  logic [15:0] pay;
  logic clr_act;
  logic wr_data;
  logic wr_gain;
  logic wr_offset;
  logic wr_clear;
  logic wr_ctrl;

  assign sclk_fall = s_reg.sclk_f & ~filt(s_reg.sclk_s, s_reg.sclk_f);
  assign frame_end = ~s_reg.frame_f & filt(s_reg.frame_s, s_reg.frame_f);
  // With the check code enabled the command word is the first 24 bits; the code itself is not verified here.
  assign word = check_enable ? s_reg.shift[31:8] : s_reg.shift[23:0];
  assign need = check_enable ? dtr_pkg::FRAME_BITS_CHECK : dtr_pkg::FRAME_BITS;
  assign frame_ok = frame_end && (s_reg.cnt == need) && !word[dtr_pkg::RW_BIT]
    && (word[dtr_pkg::DEV_HI:dtr_pkg::DEV_LO] == {s_reg.strap_hi_f, s_reg.strap_lo_f});
  assign sel = word[dtr_pkg::SEL_HI:dtr_pkg::SEL_LO];
  assign ch = word[dtr_pkg::CH_HI:dtr_pkg::CH_LO];
  assign pay = word[15:0];
  assign clr_act = ~s_reg.clr_f;
  // These decode strobes feed only the checks below, so the write logic stays a single case.
  assign wr_data = frame_ok && (sel == dtr_pkg::SEL_DATA);
  assign wr_gain = frame_ok && ((sel == dtr_pkg::SEL_GAIN_ONE) || (sel == dtr_pkg::SEL_GAIN_ALL));
  assign wr_offset = frame_ok && ((sel == dtr_pkg::SEL_OFFSET_ONE) || (sel == dtr_pkg::SEL_OFFSET_ALL));
  assign wr_clear = frame_ok && (sel == dtr_pkg::SEL_CLEAR);
  assign wr_ctrl = frame_ok && (sel == dtr_pkg::SEL_CTRL);

  always_comb begin
    logic [3:0] m;
    s_next = s_reg;
    m = 4'h0;
    s_next.sclk_s = {s_reg.sclk_s[1:0], sclk};
    s_next.frame_s = {s_reg.frame_s[1:0], frame_sel_n};
    s_next.sdin_s = {s_reg.sdin_s[1:0], sdin};
    s_next.clr_s = {s_reg.clr_s[1:0], clear_n};
    s_next.strap_hi_s = {s_reg.strap_hi_s[1:0], addr_strap_high};
    s_next.strap_lo_s = {s_reg.strap_lo_s[1:0], addr_strap_low};
    s_next.sclk_f = filt(s_reg.sclk_s, s_reg.sclk_f);
    s_next.frame_f = filt(s_reg.frame_s, s_reg.frame_f);
    s_next.sdin_f = filt(s_reg.sdin_s, s_reg.sdin_f);
    s_next.clr_f = filt(s_reg.clr_s, s_reg.clr_f);
    s_next.strap_hi_f = filt(s_reg.strap_hi_s, s_reg.strap_hi_f);
    s_next.strap_lo_f = filt(s_reg.strap_lo_s, s_reg.strap_lo_f);
    s_next.ctrl.valid = 1'b0;
    if (s_reg.frame_f) begin
      s_next.cnt = 6'h00;
    end else if (sclk_fall) begin
      s_next.shift = {s_reg.shift[30:0], s_reg.sdin_f};
      if (s_reg.cnt != dtr_pkg::CNT_MAX) begin
        s_next.cnt = s_reg.cnt + 6'h01;
      end
    end
    if (frame_ok) begin
      unique case (sel)
        dtr_pkg::SEL_DATA: begin
          m = chan_mask(1'b0, ch);
          for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
              s_next.out_code[i] = pay;
            end
          end
        end
        dtr_pkg::SEL_GAIN_ONE, dtr_pkg::SEL_GAIN_ALL: begin
          m = chan_mask(sel == dtr_pkg::SEL_GAIN_ALL, ch);
          for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
              s_next.gain[i] = pay;
            end
          end
        end
        dtr_pkg::SEL_OFFSET_ONE, dtr_pkg::SEL_OFFSET_ALL: begin
          m = chan_mask(sel == dtr_pkg::SEL_OFFSET_ALL, ch);
          for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
              s_next.offset[i] = pay;
            end
          end
        end
        dtr_pkg::SEL_CLEAR: begin
          s_next.clear_code[ch] = pay;
        end
        dtr_pkg::SEL_CTRL: begin
          s_next.ctrl.valid = 1'b1;
          s_next.ctrl.sub_select = word[dtr_pkg::SUB_HI:dtr_pkg::SUB_LO];
          s_next.ctrl.channel_select = ch;
          s_next.ctrl.data = word[dtr_pkg::CTRL_DATA_HI:0];
          if (word[dtr_pkg::SUB_HI:dtr_pkg::SUB_LO] == dtr_pkg::SUB_DAC_CTRL) begin
            s_next.clr_en[ch] = word[dtr_pkg::CLR_EN_BIT];
          end
        end
        default: begin
          m = 4'h0;
        end
      endcase
    end
    // Clear is a level: while it is held, enabled channels keep their clear value over any data write.
    for (int i = 0; i < 4; i++) begin
      if (clr_act && s_reg.clr_en[i]) begin
        s_next.out_code[i] = s_reg.clear_code[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.sclk_s <= 3'h7;
      s_reg.sclk_f <= 1'b1;
      s_reg.frame_s <= 3'h7;
      s_reg.frame_f <= 1'b1;
      s_reg.clr_s <= 3'h7;
      s_reg.clr_f <= 1'b1;
      s_reg.gain <= {4{dtr_pkg::GAIN_RST}};
      s_reg.offset <= {4{dtr_pkg::OFFSET_RST}};
      s_reg.clear_code <= {4{dtr_pkg::CLEAR_RST}};
      s_reg.out_code <= {4{dtr_pkg::DATA_RST}};
      s_reg.clr_en <= dtr_pkg::CLR_EN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign channel_output_code = s_reg.out_code;
  assign channel_gain_trim = s_reg.gain;
  assign channel_offset_trim = s_reg.offset;
  assign channel_clear_value = s_reg.clear_code;
  assign clear_enable = s_reg.clr_en;
  assign ctrl_write = s_reg.ctrl;

  AST_GAIN_RST: assert property (@(posedge core_clk) disable iff (srst)
    $fell(srst) |-> (s_reg.gain == {4{dtr_pkg::GAIN_RST}})) else $error("gain trim not all ones after reset");
  AST_OFFSET_RST: assert property (@(posedge core_clk) disable iff (srst)
    $fell(srst) |-> (s_reg.offset == {4{dtr_pkg::OFFSET_RST}})) else $error("offset trim not mid-scale after reset");
  AST_CLEAR_RST: assert property (@(posedge core_clk) disable iff (srst)
    $fell(srst) |-> (s_reg.clear_code == {4{dtr_pkg::CLEAR_RST}})) else $error("clear value not zero after reset");
  AST_GAIN_ONE: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == dtr_pkg::SEL_GAIN_ONE) |=>
    (s_reg.gain[$past(ch)] == $past(pay)) && (s_reg.gain[$past(ch) + 2'd1] == $past(s_reg.gain[ch + 2'd1])))
    else $error("single gain write wrong");
  AST_GAIN_ALL: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == dtr_pkg::SEL_GAIN_ALL) |=> (s_reg.gain == {4{$past(pay)}}))
    else $error("broadcast gain write wrong");
  AST_OFFSET_ONE: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == dtr_pkg::SEL_OFFSET_ONE) |=>
    (s_reg.offset[$past(ch)] == $past(pay)) && (s_reg.offset[$past(ch) + 2'd2] == $past(s_reg.offset[ch + 2'd2])))
    else $error("single offset write wrong");
  AST_OFFSET_ALL: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == dtr_pkg::SEL_OFFSET_ALL) |=> (s_reg.offset == {4{$past(pay)}}))
    else $error("broadcast offset write wrong");
  AST_CLEAR_CODE: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == dtr_pkg::SEL_CLEAR) |=> (s_reg.clear_code[$past(ch)] == $past(pay)))
    else $error("clear value write wrong");
  AST_CTRL: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == dtr_pkg::SEL_CTRL) |=> ctrl_write.valid ##1 !ctrl_write.valid)
    else $error("control write pulse wrong");
  AST_DATA: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == dtr_pkg::SEL_DATA && !(clr_act && s_reg.clr_en[ch])) |=>
    (s_reg.out_code[$past(ch)] == $past(pay))) else $error("output code write wrong");
  AST_PARTIAL: assert property (@(posedge core_clk) disable iff (srst)
    (frame_end && s_reg.cnt != need) |=> ($stable(s_reg.gain) && $stable(s_reg.offset) && $stable(s_reg.clear_code)))
    else $error("partial frame changed a register");
  AST_STRAP: assert property (@(posedge core_clk) disable iff (srst)
    (frame_end && word[dtr_pkg::DEV_HI:dtr_pkg::DEV_LO] != {s_reg.strap_hi_f, s_reg.strap_lo_f}) |=>
    ($stable(s_reg.gain) && $stable(s_reg.offset) && !ctrl_write.valid)) else $error("frame for other device acted on");
  AST_CLR_FORCE: assert property (@(posedge core_clk) disable iff (srst)
    (clr_act && s_reg.clr_en[0]) |=> (s_reg.out_code[0] == $past(s_reg.clear_code[0])))
    else $error("enabled channel not forced to clear value");

  AST_CLR_FORCE_B: assert property (@(posedge core_clk) disable iff (srst)
    (clr_act && s_reg.clr_en[1]) |=> (s_reg.out_code[1] == $past(s_reg.clear_code[1])))
    else $error("enabled channel B not forced to clear value");
  AST_CLR_FORCE_C: assert property (@(posedge core_clk) disable iff (srst)
    (clr_act && s_reg.clr_en[2]) |=> (s_reg.out_code[2] == $past(s_reg.clear_code[2])))
    else $error("enabled channel C not forced to clear value");
  AST_CLR_FORCE_D: assert property (@(posedge core_clk) disable iff (srst)
    (clr_act && s_reg.clr_en[3]) |=> (s_reg.out_code[3] == $past(s_reg.clear_code[3])))
    else $error("enabled channel D not forced to clear value");

  AST_GAIN_ONE_NB2: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == dtr_pkg::SEL_GAIN_ONE) |=> (s_reg.gain[$past(ch) + 2'd2] == $past(s_reg.gain[ch + 2'd2])))
    else $error("single gain write touched another channel");
  AST_GAIN_ONE_NB3: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == dtr_pkg::SEL_GAIN_ONE) |=> (s_reg.gain[$past(ch) + 2'd3] == $past(s_reg.gain[ch + 2'd3])))
    else $error("single gain write touched another channel");
  AST_OFFSET_ONE_NB1: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == dtr_pkg::SEL_OFFSET_ONE) |=> (s_reg.offset[$past(ch) + 2'd1] == $past(s_reg.offset[ch + 2'd1])))
    else $error("single offset write touched another channel");
  AST_OFFSET_ONE_NB3: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == dtr_pkg::SEL_OFFSET_ONE) |=> (s_reg.offset[$past(ch) + 2'd3] == $past(s_reg.offset[ch + 2'd3])))
    else $error("single offset write touched another channel");

  AST_CLEAR_NB1: assert property (@(posedge core_clk) disable iff (srst)
    wr_clear |=> (s_reg.clear_code[$past(ch) + 2'd1] == $past(s_reg.clear_code[ch + 2'd1])))
    else $error("clear value write touched another channel");
  AST_CLEAR_NB2: assert property (@(posedge core_clk) disable iff (srst)
    wr_clear |=> (s_reg.clear_code[$past(ch) + 2'd2] == $past(s_reg.clear_code[ch + 2'd2])))
    else $error("clear value write touched another channel");
  AST_CLEAR_NB3: assert property (@(posedge core_clk) disable iff (srst)
    wr_clear |=> (s_reg.clear_code[$past(ch) + 2'd3] == $past(s_reg.clear_code[ch + 2'd3])))
    else $error("clear value write touched another channel");

  AST_DATA_NB1: assert property (@(posedge core_clk) disable iff (srst)
    (wr_data && !clr_act) |=> (s_reg.out_code[$past(ch) + 2'd1] == $past(s_reg.out_code[ch + 2'd1])))
    else $error("output code write touched another channel");
  AST_DATA_NB2: assert property (@(posedge core_clk) disable iff (srst)
    (wr_data && !clr_act) |=> (s_reg.out_code[$past(ch) + 2'd2] == $past(s_reg.out_code[ch + 2'd2])))
    else $error("output code write touched another channel");
  AST_DATA_NB3: assert property (@(posedge core_clk) disable iff (srst)
    (wr_data && !clr_act) |=> (s_reg.out_code[$past(ch) + 2'd3] == $past(s_reg.out_code[ch + 2'd3])))
    else $error("output code write touched another channel");
  AST_DATA_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    (!wr_data && !clr_act) |=> $stable(s_reg.out_code))
    else $error("output code changed without a write or clear");
  AST_CLR_WINS: assert property (@(posedge core_clk) disable iff (srst)
    (wr_data && clr_act && s_reg.clr_en[ch]) |=> (s_reg.out_code[$past(ch)] == $past(s_reg.clear_code[ch])))
    else $error("data write overrode an active clear");

  AST_GAIN_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !wr_gain |=> $stable(s_reg.gain))
    else $error("gain trim changed without a complete gain frame");
  AST_OFFSET_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !wr_offset |=> $stable(s_reg.offset))
    else $error("offset trim changed without a complete offset frame");
  AST_CLEAR_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !wr_clear |=> $stable(s_reg.clear_code))
    else $error("clear value changed without a complete clear frame");

  AST_CLR_EN_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !(wr_ctrl && (word[dtr_pkg::SUB_HI:dtr_pkg::SUB_LO] == dtr_pkg::SUB_DAC_CTRL)) |=> $stable(s_reg.clr_en))
    else $error("clear enable changed without a channel control frame");
  AST_CLR_EN_WRITE: assert property (@(posedge core_clk) disable iff (srst)
    (wr_ctrl && (word[dtr_pkg::SUB_HI:dtr_pkg::SUB_LO] == dtr_pkg::SUB_DAC_CTRL)) |=> (s_reg.clr_en[$past(ch)] == $past(word[dtr_pkg::CLR_EN_BIT])))
    else $error("clear enable not taken from channel control frame");
  AST_CTRL_FIELDS: assert property (@(posedge core_clk) disable iff (srst)
    wr_ctrl |=> (ctrl_write.sub_select == $past(word[dtr_pkg::SUB_HI:dtr_pkg::SUB_LO]))
    && (ctrl_write.channel_select == $past(ch)) && (ctrl_write.data == $past(word[dtr_pkg::CTRL_DATA_HI:0])))
    else $error("control write fields wrong");
  AST_CTRL_ONLY: assert property (@(posedge core_clk) disable iff (srst)
    ctrl_write.valid |-> $past(wr_ctrl))
    else $error("control write pulse without a control frame");
  AST_CTRL_HOLD: assert property (@(posedge core_clk) disable iff (srst)
    !wr_ctrl |=> ($stable(ctrl_write.sub_select) && $stable(ctrl_write.channel_select)
    && $stable(ctrl_write.data)))
    else $error("control write fields changed without a control frame");
  AST_CTRL_NO_TRIM: assert property (@(posedge core_clk) disable iff (srst)
    wr_ctrl |=> ($stable(s_reg.gain) && $stable(s_reg.offset) && $stable(s_reg.clear_code)))
    else $error("control frame changed a trim register");

  AST_READ_IGNORED: assert property (@(posedge core_clk) disable iff (srst)
    (frame_end && (s_reg.cnt == need) && word[dtr_pkg::RW_BIT]) |=>
    ($stable(s_reg.gain) && $stable(s_reg.offset) && $stable(s_reg.clear_code) && !ctrl_write.valid))
    else $error("read frame acted on");
  AST_SEL_UNUSED: assert property (@(posedge core_clk) disable iff (srst)
    (frame_ok && sel == 3'h1) |=> ($stable(s_reg.gain) && $stable(s_reg.offset) && $stable(s_reg.clear_code) && !ctrl_write.valid))
    else $error("unused register select acted on");

  AST_DATA_RST: assert property (@(posedge core_clk) disable iff (srst)
    $fell(srst) |-> (s_reg.out_code == {4{dtr_pkg::DATA_RST}}))
    else $error("output code not zero after reset");
  AST_CLR_EN_RST: assert property (@(posedge core_clk) disable iff (srst)
    $fell(srst) |-> (s_reg.clr_en == dtr_pkg::CLR_EN_RST))
    else $error("clear enable not off after reset");
  AST_CTRL_RST: assert property (@(posedge core_clk) disable iff (srst)
    $fell(srst) |-> !ctrl_write.valid)
    else $error("control write pulse right after reset");

  AST_CNT_IDLE: assert property (@(posedge core_clk) disable iff (srst)
    s_reg.frame_f |=> (s_reg.cnt == 6'h00))
    else $error("bit count not cleared between frames");
  AST_SHIFT_IN: assert property (@(posedge core_clk) disable iff (srst)
    (sclk_fall && !s_reg.frame_f) |=> (s_reg.shift[0] == $past(s_reg.sdin_f)))
    else $error("serial bit not shifted in");
  AST_CNT_STEP: assert property (@(posedge core_clk) disable iff (srst)
    (sclk_fall && !s_reg.frame_f && s_reg.cnt != dtr_pkg::CNT_MAX) |=> (s_reg.cnt == $past(s_reg.cnt) + 6'h01))
    else $error("bit count did not advance");
  AST_CNT_SAT: assert property (@(posedge core_clk) disable iff (srst)
    (sclk_fall && !s_reg.frame_f && s_reg.cnt == dtr_pkg::CNT_MAX) |=> (s_reg.cnt == dtr_pkg::CNT_MAX))
    else $error("bit count wrapped");
  AST_FRAME_PULSE: assert property (@(posedge core_clk) disable iff (srst)
    frame_ok |=> !frame_ok)
    else $error("frame accepted twice");

  AST_SCLK_FILT: assert property (@(posedge core_clk) disable iff (srst)
    (s_reg.sclk_s[2] != s_reg.sclk_s[1]) |=> $stable(s_reg.sclk_f))
    else $error("serial clock taken before stages agree");
  AST_SCLK_TAKE: assert property (@(posedge core_clk) disable iff (srst)
    (s_reg.sclk_s[2] == s_reg.sclk_s[1]) |=> (s_reg.sclk_f == $past(s_reg.sclk_s[2])))
    else $error("serial clock not taken once stages agree");
  AST_SDIN_FILT: assert property (@(posedge core_clk) disable iff (srst)
    (s_reg.sdin_s[2] != s_reg.sdin_s[1]) |=> $stable(s_reg.sdin_f))
    else $error("serial data taken before stages agree");
  AST_FRAME_FILT: assert property (@(posedge core_clk) disable iff (srst)
    (s_reg.frame_s[2] != s_reg.frame_s[1]) |=> $stable(s_reg.frame_f))
    else $error("frame select taken before stages agree");
  AST_CLR_FILT: assert property (@(posedge core_clk) disable iff (srst)
    (s_reg.clr_s[2] != s_reg.clr_s[1]) |=> $stable(s_reg.clr_f))
    else $error("clear pin taken before stages agree");
  AST_STRAP_HI_FILT: assert property (@(posedge core_clk) disable iff (srst)
    (s_reg.strap_hi_s[2] != s_reg.strap_hi_s[1]) |=> $stable(s_reg.strap_hi_f))
    else $error("high strap taken before stages agree");
  AST_STRAP_LO_FILT: assert property (@(posedge core_clk) disable iff (srst)
    (s_reg.strap_lo_s[2] != s_reg.strap_lo_s[1]) |=> $stable(s_reg.strap_lo_f))
    else $error("low strap taken before stages agree");
endmodule : dtr_regs
`default_nettype wire

/* File: dtr_pkg.sv */
// Constants, field layout and carrier types of the serial input word decoder and trim registers.
// Assumes a single core clock domain; serial pins are synchronised inside the top module.
package dtr_pkg;
  localparam logic [5:0] FRAME_BITS = 6'h18;
  localparam logic [5:0] FRAME_BITS_CHECK = 6'h20;
  localparam int RW_BIT = 23;
  localparam int DEV_HI = 22;
  localparam int DEV_LO = 21;
  localparam int SEL_HI = 20;
  localparam int SEL_LO = 18;
  localparam int CH_HI = 17;
  localparam int CH_LO = 16;
  localparam int SUB_HI = 15;
  localparam int SUB_LO = 13;
  localparam int CTRL_DATA_HI = 12;
  localparam int CLR_EN_BIT = 2;
  localparam logic [2:0] SEL_DATA = 3'h0;
  localparam logic [2:0] SEL_GAIN_ONE = 3'h2;
  localparam logic [2:0] SEL_GAIN_ALL = 3'h3;
  localparam logic [2:0] SEL_OFFSET_ONE = 3'h4;
  localparam logic [2:0] SEL_OFFSET_ALL = 3'h5;
  localparam logic [2:0] SEL_CLEAR = 3'h6;
  localparam logic [2:0] SEL_CTRL = 3'h7;
  localparam logic [2:0] SUB_DAC_CTRL = 3'h2;
  localparam logic [15:0] GAIN_RST = 16'hffff;
  localparam logic [15:0] OFFSET_RST = 16'h8000;
  localparam logic [15:0] CLEAR_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [3:0] CLR_EN_RST = 4'h0;
  localparam logic [5:0] CNT_MAX = 6'h3f;

  typedef struct packed {
    logic valid;
    logic [2:0] sub_select;
    logic [1:0] channel_select;
    logic [12:0] data;
  } dtr_ctrl_wr_t;

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] frame_s;
    logic [2:0] sdin_s;
    logic [2:0] clr_s;
    logic [2:0] strap_hi_s;
    logic [2:0] strap_lo_s;
    logic sclk_f;
    logic frame_f;
    logic sdin_f;
    logic clr_f;
    logic strap_hi_f;
    logic strap_lo_f;
    logic [31:0] shift;
    logic [5:0] cnt;
    logic [3:0][15:0] gain;
    logic [3:0][15:0] offset;
    logic [3:0][15:0] clear_code;
    logic [3:0][15:0] out_code;
    logic [3:0] clr_en;
    dtr_ctrl_wr_t ctrl;
  } dtr_state_t;
endpackage : dtr_pkg

/* File: dtr_ctrl_model.sv */
// Behavioural serial controller that shifts frames into the trim register block.
// Assumes the block takes a bit on each falling serial clock edge while frame select is low.
`timescale 1ns/1ps
`default_nettype none
module dtr_ctrl_model (
  input wire logic core_clk,
  output logic sclk,
  output logic frame_sel_n,
  output logic sdin
);
  initial begin
    sclk = 1'b1;
    frame_sel_n = 1'b1;
    sdin = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // Any payload code is sent as given, since trim range advice is left to software.
  task automatic send(input logic [31:0] w, input int n);
    frame_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      tick(6);
      sdin = w[i];
      tick(6);
      sclk = 1'b0;
      tick(6);
      sclk = 1'b1;
    end
    tick(6);
    frame_sel_n = 1'b1;
    // The data line is inverted once released so a stale bit cannot look valid.
    sdin = ~sdin;
    tick(12);
  endtask : send
endmodule : dtr_ctrl_model
`default_nettype wire

/* File: dtr_regs_tb.sv */
// Self-checking bench for the serial word decoder and trim registers.
// Assumes the controller model and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dtr_regs_tb;
  typedef logic [3:0][3:0][15:0] dtr_snap_t;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clear_n = 1'b1;
  logic check_enable = 1'b0;
  logic [1:0] strap = 2'h2;
  logic sclk, frame_sel_n, sdin;
  logic [3:0][15:0] out_c, gain, offs, clrv;
  logic [3:0] clear_enable;
  dtr_pkg::dtr_ctrl_wr_t ctrl_write;
  dtr_snap_t exp_s, prev_s, cur_s;
  dtr_snap_t snap_q[$];
  logic [18:0] ctrl_q[$];
  logic [2:0] sels[6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  integer seed = 32'h01f7;
  logic armed = 1'b0;
  always #20 core_clk = ~core_clk;
  assign cur_s = {out_c, gain, offs, clrv};
  dtr_regs dtr_regs_inst (.core_clk(core_clk), .srst(srst), .sclk(sclk), .frame_sel_n(frame_sel_n),
    .sdin(sdin), .clear_n(clear_n), .addr_strap_high(strap[1]), .addr_strap_low(strap[0]),
    .check_enable(check_enable), .channel_output_code(out_c), .channel_gain_trim(gain),
    .channel_offset_trim(offs), .channel_clear_value(clrv), .clear_enable(clear_enable),
    .ctrl_write(ctrl_write));
  dtr_ctrl_model dtr_ctrl_model_inst (.core_clk(core_clk), .sclk(sclk), .frame_sel_n(frame_sel_n), .sdin(sdin));
  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic send(input logic [23:0] w);
    if (check_enable) dtr_ctrl_model_inst.send({w, 8'h5a}, 32);
    else dtr_ctrl_model_inst.send({8'h00, w}, 24);
  endtask : send
  task automatic wr(input logic [2:0] sel, input logic [1:0] ch, input logic [15:0] d);
    case (sel)
      3'h0: exp_s[3][ch] = d;
      3'h2: exp_s[2][ch] = d;
      3'h3: exp_s[2] = {4{d}};
      3'h4: exp_s[1][ch] = d;
      3'h5: exp_s[1] = {4{d}};
      3'h6: exp_s[0][ch] = d;
      3'h7: ctrl_q.push_back({1'b1, d[15:13], ch, d[12:0]});
      default: ;
    endcase
    if (sel != 3'h7 && sel != 3'h1) snap_q.push_back(exp_s);
    send({1'b0, strap, sel, ch, d});
  endtask : wr
  // Outputs are compared on the falling edge, where the rising edge updates have settled.
  always @(negedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end else begin
      if (armed && cur_s !== prev_s) chk("registers", snap_q.size() > 0 ? snap_q.pop_front() : '0, cur_s);
      if (armed && ctrl_write.valid === 1'b1) chk("ctrl", 256'(ctrl_q.size() > 0 ? ctrl_q.pop_front() : 19'h0_0000),
        256'(ctrl_write));
      prev_s = cur_s;
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 srst = 1'b0;
    repeat (6) @(posedge core_clk);
    #1 exp_s = {{4{16'h0000}}, {4{16'hffff}}, {4{16'h8000}}, {4{16'h0000}}};
    chk("reset", exp_s, cur_s);
    chk("clear_enable", 256'(4'h0), 256'(clear_enable));
    armed = 1'b1;
    foreach (sels[k]) repeat (2) wr(sels[k], 2'($random(seed)), 16'($random(seed)));
    wr(3'h1, 2'h0, 16'h1234);
    send({1'b1, strap, 3'h2, 2'h0, 16'h0001});
    send({1'b0, ~strap, 3'h2, 2'h0, 16'h0002});
    dtr_ctrl_model_inst.send(32'h0000_1234, 23);
    check_enable = 1'b1;
    wr(3'h2, 2'h2, 16'h3c3c);
    dtr_ctrl_model_inst.send({8'h00, 1'b0, strap, 3'h2, 2'h2, 16'h0005}, 24);
    check_enable = 1'b0;
    strap = 2'h1;
    wr(3'h4, 2'h3, 16'h1111);
    send({1'b0, 2'h2, 3'h4, 2'h3, 16'h2222});
    wr(3'h7, 2'h1, 16'h4004);
    chk("clear_enable", 256'(4'h2), 256'(clear_enable));
    wr(3'h7, 2'h3, 16'h0004);
    chk("clear_enable", 256'(4'h2), 256'(clear_enable));
    wr(3'h6, 2'h1, ~exp_s[3][1]);
    exp_s[3][1] = exp_s[0][1];
    snap_q.push_back(exp_s);
    clear_n = 1'b0;
    repeat (10) @(posedge core_clk);
    #1 clear_n = 1'b1;
    repeat (10) @(posedge core_clk);
    chk("pending", 256'(0), 256'(snap_q.size() + ctrl_q.size()));
    close_out();
  end
endmodule : dtr_regs_tb
`default_nettype wire
